// [rtl/swc_ctrl.sv]
// Sleep and wake controller top: AXI4-Lite registers, sleep sequencing, wake sorting.
// Assumes the core pulses sleepExec with the sleep address, on core_clk.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
module swc_ctrl (
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    input  wire logic [11:0]                    s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [11:0]                    s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    input  wire logic                           sleepExec,
    input  wire logic [swc_pkg::PADDR_W-1:0]    sleepAddr,
    input  wire logic                           wdogTick,
    input  wire logic [swc_pkg::IRQ_W-1:0]      irqFlags,
    input  wire swc_pkg::swc_rst_src_t          rstSrcPin,
    output logic                                cpuClkEnable,
    output logic                                deviceReset,
    output swc_pkg::swc_wake_t                  wakeInfo,
    output logic                                lowFreqOscEnable,
    output logic                                secTimerOscEnable,
    output logic                                capSenseOscEnable,
    output logic                                adcClockEnable,
    output logic                                portHold,
    output logic                                wdogTimeout
);
    import swc_pkg::*;

    // Pin-level sources and the external interrupt pins pass two flops first
    logic [4:0]       rstSync;
    logic [IRQ_W-1:0] irqSync;
    swc_rst_src_t     rstSrc;

    swc_sync #(.W(5 + IRQ_W)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .asyncIn  ({rstSrcPin, irqFlags}),
        .syncOut  ({rstSync, irqSync})
    );
    assign rstSrc = swc_rst_src_t'(rstSync);

    // Registers
    swc_state_t          state_reg,  state_next;
    logic [2:0]          ctrl_reg,   ctrl_next;
    logic [IRQ_W-1:0]    irqEn_reg,  irqEn_next;
    logic [WDOG_W-1:0]   wdog_reg,   wdog_next;
    logic                pdFlag_reg, pdFlag_next;
    logic                toFlag_reg, toFlag_next;
    logic [PADDR_W-1:0]  fetch_reg,  fetch_next;
    swc_wake_t           wake_reg,   wake_next;
    logic                cpuEn_reg,  cpuEn_next;
    logic                devRst_reg, devRst_next;
    logic                hold_reg,   hold_next;
    logic                wdTo_reg,   wdTo_next;
    logic                adcEn_reg,  adcEn_next;
    logic                awrdy_reg,  awrdy_next;
    logic                wrdy_reg,   wrdy_next;
    logic                bvalid_reg, bvalid_next;
    logic [1:0]          bresp_reg,  bresp_next;
    logic                arrdy_reg,  arrdy_next;
    logic                rvalid_reg, rvalid_next;
    logic [1:0]          rresp_reg,  rresp_next;
    logic [31:0]         rdata_reg,  rdata_next;
    logic                awHeld_reg, awHeld_next;
    logic [11:0]         awAddr_reg, awAddr_next;
    logic                wHeld_reg,  wHeld_next;
    logic [31:0]         wData_reg,  wData_next;

    logic fullReset;
    logic irqWake;
    logic wdogWake;
    logic doWrite;
    logic [11:0] wrAddr;
    logic [31:0] wrData;

    assign fullReset = (rstSrc.mclrPin & rstSrc.mclrEnable) | (rstSrc.brownOut & rstSrc.brownOutEnable)
                       | rstSrc.powerOn;
    assign irqWake   = |(irqSync & irqEn_reg);
    assign wdogWake  = ctrl_reg[CTRL_WDTEN_BIT] && (wdog_reg == WDOG_LIMIT);
    assign wrAddr    = awHeld_reg ? awAddr_reg : s_axi_awaddr;
    assign wrData    = wHeld_reg ? wData_reg : s_axi_wdata;
    assign doWrite   = (awHeld_reg || (s_axi_awvalid && awrdy_reg))
                       && (wHeld_reg || (s_axi_wvalid && wrdy_reg)) && !bvalid_reg;

    // Sleep sequencing
    always_comb begin
        state_next  = state_reg;
        wdog_next   = wdog_reg;
        pdFlag_next = pdFlag_reg;
        toFlag_next = toFlag_reg;
        fetch_next  = fetch_reg;
        wake_next   = wake_reg;
        cpuEn_next  = cpuEn_reg;
        devRst_next = 1'b0;
        hold_next   = hold_reg;
        wdTo_next   = 1'b0;
        adcEn_next  = 1'b1;
        wake_next.resumed = 1'b0;
        wake_next.callIsr = 1'b0;
        if (ctrl_reg[CTRL_WDTEN_BIT] && wdogTick && !wdogWake) begin
            wdog_next = wdog_reg + 16'h0001;
        end
        unique case (state_reg)
            SWC_RUN: begin
                if (sleepExec) begin
                    state_next  = SWC_ENTER;
                    wdog_next   = '0;
                    pdFlag_next = 1'b0;
                    toFlag_next = 1'b1;
                    cpuEn_next  = 1'b0;
                    hold_next   = 1'b1;
                    fetch_next  = PADDR_W'(sleepAddr + 15'h0001);
                end else if (wdogWake) begin
                    wdTo_next = 1'b1;
                    wdog_next = '0;
                end
            end
            SWC_ENTER: begin
                state_next = SWC_SLEEP;
            end
            SWC_SLEEP: begin
                // ADC only runs on its own RC clock while the system clock is stopped
                adcEn_next = ctrl_reg[CTRL_ADCRC_BIT];
                if (fullReset) begin
                    devRst_next = 1'b1;
                end else if (wdogWake || irqWake) begin
                    state_next = SWC_RESUME;
                    wdog_next  = '0;
                    if (wdogWake) begin
                        toFlag_next = 1'b0;
                    end
                    cpuEn_next = 1'b1;
                    hold_next  = 1'b0;
                end
            end
            SWC_RESUME: begin
                // Core now executes fetchAddr first; the vector request follows it
                state_next        = SWC_RUN;
                wake_next.resumed = 1'b1;
                wake_next.callIsr = ctrl_reg[CTRL_GIE_BIT] && irqWake;
            end
            default: begin
                state_next = SWC_RUN;
            end
        endcase
        wake_next.fetchAddr = fetch_next;
        // Full reset from any state; watchdog is the only source touched by sleep
        if (fullReset) begin
            state_next  = SWC_RUN;
            devRst_next = 1'b1;
            cpuEn_next  = 1'b1;
            hold_next   = 1'b0;
            wdog_next   = '0;
            pdFlag_next = 1'b1;
            toFlag_next = 1'b1;
        end
    end

    // AXI4-Lite slave; address and data taken in either order
    always_comb begin
        awrdy_next  = awrdy_reg;
        wrdy_next   = wrdy_reg;
        awHeld_next = awHeld_reg;
        awAddr_next = awAddr_reg;
        wHeld_next  = wHeld_reg;
        wData_next  = wData_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        ctrl_next   = ctrl_reg;
        irqEn_next  = irqEn_reg;
        if (s_axi_awvalid && awrdy_reg) begin
            awHeld_next = 1'b1;
            awAddr_next = s_axi_awaddr;
            awrdy_next  = 1'b0;
        end
        if (s_axi_wvalid && wrdy_reg) begin
            wHeld_next = 1'b1;
            wData_next = s_axi_wdata;
            wrdy_next  = 1'b0;
        end
        if (doWrite) begin
            awHeld_next = 1'b0;
            wHeld_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = RESP_OKAY;
            unique case (wrAddr)
                CTRL_OFFSET:  if (s_axi_wstrb[0] || wHeld_reg) ctrl_next = wrData[2:0];
                IRQEN_OFFSET: if (s_axi_wstrb[0] || wHeld_reg) irqEn_next = wrData[IRQ_W-1:0];
                STATUS_OFFSET, WDOG_OFFSET, PADDR_OFFSET, WAKE_OFFSET: bresp_next = RESP_OKAY;
                default: bresp_next = RESP_SLVERR;
            endcase
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
            awrdy_next  = 1'b1;
            wrdy_next   = 1'b1;
        end
    end

    always_comb begin
        arrdy_next  = arrdy_reg;
        rvalid_next = rvalid_reg;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        if (s_axi_arvalid && arrdy_reg) begin
            arrdy_next  = 1'b0;
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            unique case (s_axi_araddr)
                CTRL_OFFSET:   rdata_next[2:0] = ctrl_reg;
                STATUS_OFFSET: rdata_next[2:0] = {state_reg == SWC_SLEEP, toFlag_reg, pdFlag_reg};
                IRQEN_OFFSET:  rdata_next[IRQ_W-1:0] = irqEn_reg;
                WDOG_OFFSET:   rdata_next[WDOG_W-1:0] = wdog_reg;
                PADDR_OFFSET:  rdata_next[PADDR_W-1:0] = fetch_reg;
                WAKE_OFFSET:   rdata_next[IRQ_W-1:0] = irqSync;
                default:       rresp_next = RESP_SLVERR;
            endcase
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
            arrdy_next  = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg  <= SWC_RUN;
            ctrl_reg   <= CTRL_RESET;
            irqEn_reg  <= IRQEN_RESET;
            wdog_reg   <= '0;
            pdFlag_reg <= 1'b1;
            toFlag_reg <= 1'b1;
            fetch_reg  <= '0;
            wake_reg   <= '0;
            cpuEn_reg  <= 1'b1;
            devRst_reg <= 1'b0;
            hold_reg   <= 1'b0;
            wdTo_reg   <= 1'b0;
            adcEn_reg  <= 1'b1;
            awrdy_reg  <= 1'b1;
            wrdy_reg   <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
            arrdy_reg  <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= '0;
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wHeld_reg  <= 1'b0;
            wData_reg  <= '0;
        end else begin
            state_reg  <= state_next;
            ctrl_reg   <= ctrl_next;
            irqEn_reg  <= irqEn_next;
            wdog_reg   <= wdog_next;
            pdFlag_reg <= pdFlag_next;
            toFlag_reg <= toFlag_next;
            fetch_reg  <= fetch_next;
            wake_reg   <= wake_next;
            cpuEn_reg  <= cpuEn_next;
            devRst_reg <= devRst_next;
            hold_reg   <= hold_next;
            wdTo_reg   <= wdTo_next;
            adcEn_reg  <= adcEn_next;
            awrdy_reg  <= awrdy_next;
            wrdy_reg   <= wrdy_next;
            bvalid_reg <= bvalid_next;
            bresp_reg  <= bresp_next;
            arrdy_reg  <= arrdy_next;
            rvalid_reg <= rvalid_next;
            rresp_reg  <= rresp_next;
            rdata_reg  <= rdata_next;
            awHeld_reg <= awHeld_next;
            awAddr_reg <= awAddr_next;
            wHeld_reg  <= wHeld_next;
            wData_reg  <= wData_next;
        end
    end

    // Slow oscillators are never stopped by sleep; kept as flops to meet the output style
    logic oscOn_reg;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            oscOn_reg <= 1'b1;
        end else begin
            oscOn_reg <= 1'b1;
        end
    end

    assign lowFreqOscEnable  = oscOn_reg;
    assign secTimerOscEnable = oscOn_reg;
    assign capSenseOscEnable = oscOn_reg;
    assign adcClockEnable    = adcEn_reg;
    assign cpuClkEnable      = cpuEn_reg;
    assign deviceReset       = devRst_reg;
    assign wakeInfo          = wake_reg;
    assign portHold          = hold_reg;
    assign wdogTimeout       = wdTo_reg;
    assign s_axi_awready     = awrdy_reg;
    assign s_axi_wready      = wrdy_reg;
    assign s_axi_bvalid      = bvalid_reg;
    assign s_axi_bresp       = bresp_reg;
    assign s_axi_arready     = arrdy_reg;
    assign s_axi_rvalid      = rvalid_reg;
    assign s_axi_rresp       = rresp_reg;
    assign s_axi_rdata       = rdata_reg;

    // Checks
    sequence enterSeq;
        state_reg == SWC_RUN && sleepExec && !fullReset;
    endsequence
    sequence wakeSeq;
        state_reg == SWC_SLEEP && !fullReset && (irqWake || wdogWake);
    endsequence

    chk_entry_flags: assert property (@(posedge core_clk) disable iff (rst)
        enterSeq |=> !pdFlag_reg && toFlag_reg && wdog_reg == '0) else $error("entry flags wrong");
    chk_clk_gated: assert property (@(posedge core_clk) disable iff (rst)
        enterSeq |=> !cpuClkEnable ##1 !cpuClkEnable) else $error("cpu clock not gated");
    chk_prefetch_addr: assert property (@(posedge core_clk) disable iff (rst)
        enterSeq |=> fetch_reg == PADDR_W'($past(sleepAddr) + 15'h0001)) else $error("bad prefetch address");
    chk_wake_clk: assert property (@(posedge core_clk) disable iff (rst)
        wakeSeq |=> cpuClkEnable && wdog_reg == '0 ##1 wakeInfo.resumed) else $error("wake order wrong");
    chk_isr_gie: assert property (@(posedge core_clk) disable iff (rst)
        wakeInfo.callIsr |-> wakeInfo.resumed && ctrl_reg[CTRL_GIE_BIT]) else $error("isr without enable");
    chk_no_gie_wake: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == SWC_SLEEP && !fullReset && irqWake |=> state_reg == SWC_RESUME) else $error("irq no wake");
    chk_reset_wake: assert property (@(posedge core_clk) disable iff (rst)
        fullReset |=> deviceReset && state_reg == SWC_RUN) else $error("reset wake missing");
    chk_ports_held: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == SWC_SLEEP |-> portHold) else $error("ports not held");
endmodule : swc_ctrl

// [rtl/swc_pkg.sv]
// Package for the sleep and wake controller: register map, field positions, states.
// Assumes a 20 MHz core clock and an AXI4-Lite master with 32-bit data.
// Summary of operation
// - Executing the sleep instruction enters power-down.
// - Entry clears the watchdog counter; it keeps counting if enabled in sleep.
// - Entry clears the power-down flag.
// - Entry sets the time-out flag.
// - The processor clock is gated off while powered down.
// - The low-frequency internal oscillator keeps running in power-down.
// - The secondary timer oscillator keeps running in power-down.
// - The ADC keeps converting in power-down when its dedicated RC clock is selected.
// - The capacitive sensing oscillator keeps running unchanged.
// - Port pins hold their drive state: high, low or high-impedance.
// - Sleep alters no reset source other than the watchdog.
// - Master clear, brown-out and power-on reset wake by full device reset.
// - Watchdog time-out, external and sleep-capable peripheral interrupts wake and continue.
// - The following program address is prefetched while executing sleep.
// - Only individually enabled interrupts wake; global enable does not matter.
// - Global enable clear: resume at the instruction after sleep.
// - Global enable set: execute next instruction, then call the service routine.
// - The watchdog counter is cleared on wake-up, whatever the source.
package swc_pkg;
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] IRQEN_OFFSET  = 12'h008;
    localparam logic [11:0] WDOG_OFFSET   = 12'h00C;
    localparam logic [11:0] PADDR_OFFSET  = 12'h010;
    localparam logic [11:0] WAKE_OFFSET   = 12'h014;

    localparam int CTRL_GIE_BIT     = 0;
    localparam int CTRL_WDTEN_BIT   = 1;
    localparam int CTRL_ADCRC_BIT   = 2;
    localparam int STAT_PD_BIT      = 0;
    localparam int STAT_TO_BIT      = 1;
    localparam int STAT_ASLEEP_BIT  = 2;

    localparam int IRQ_W      = 8;
    localparam int WDOG_W     = 16;
    localparam int PADDR_W    = 15;

    localparam logic [2:0]         CTRL_RESET   = 3'h0;
    localparam logic [IRQ_W-1:0]   IRQEN_RESET  = 8'h00;
    localparam logic [WDOG_W-1:0]  WDOG_LIMIT   = 16'hFFFF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SWC_RUN    = 4'b0001,
        SWC_ENTER  = 4'b0010,
        SWC_SLEEP  = 4'b0100,
        SWC_RESUME = 4'b1000
    } swc_state_t;

    typedef struct packed {
        logic mclrPin;
        logic mclrEnable;
        logic brownOut;
        logic brownOutEnable;
        logic powerOn;
    } swc_rst_src_t;

    typedef struct packed {
        logic               callIsr;
        logic               resumed;
        logic [PADDR_W-1:0] fetchAddr;
    } swc_wake_t;
endpackage : swc_pkg

// [rtl/swc_sync.sv]
// Two-flop synchroniser bank for pin-level wake and reset inputs.
// Assumes the inputs are asynchronous levels to core_clk.
module swc_sync #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule : swc_sync

// [verif/swc_core_model.sv]
// Behavioural model of the core, reset sources and interrupt peripherals around the controller.
// Assumes the bench calls its tasks just after a rising core_clk edge.
module swc_core_model (
    input  wire logic                        core_clk,
    input  wire logic                        cpuClkEnable,
    output logic                             sleepExec,
    output logic [swc_pkg::PADDR_W-1:0]      sleepAddr,
    output logic                             wdogTick,
    output logic [swc_pkg::IRQ_W-1:0]        irqFlags,
    output swc_pkg::swc_rst_src_t            rstSrcPin
);
    timeunit 1ns;
    timeprecision 1ps;
    import swc_pkg::*;
    logic tickOn;
    assign wdogTick = tickOn;
    initial begin
        sleepExec = 1'b0;
        sleepAddr = '0;
        tickOn    = 1'b0;
        irqFlags  = '0;
        rstSrcPin = '0;
    end
    // A stopped core cannot issue; the word after sleep is a no-op here
    task automatic execSleep(input logic [PADDR_W-1:0] a);
        sleepExec <= (cpuClkEnable === 1'b1);
        sleepAddr <= a;
        @(posedge core_clk);
        sleepExec <= 1'b0;
        sleepAddr <= ~a;
    endtask : execSleep
    task automatic setIrq(input logic [IRQ_W-1:0] f);
        irqFlags <= f;
        @(posedge core_clk);
    endtask : setIrq
    task automatic setRst(input swc_rst_src_t s);
        rstSrcPin <= s;
        @(posedge core_clk);
    endtask : setRst
    task automatic setTick(input logic t);
        tickOn <= t;
        @(posedge core_clk);
    endtask : setTick
endmodule : swc_core_model

// [verif/swc_ctrl_test.sv]
// Self-checking bench for the sleep and wake controller.
// Assumes the core model drives sleep, tick, interrupt and reset-source pins.
module swc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import swc_pkg::*;
    typedef struct packed {
        logic [2:0] ctrl;
        logic [7:0] irqEn;
        logic [7:0] irq;
        logic       callIsr;
    } swc_row_t;
    localparam swc_row_t ROWS [4] = '{{3'h0, 8'h01, 8'h01, 1'b0}, {3'h1, 8'h01, 8'h01, 1'b1},
                                      {3'h5, 8'h80, 8'hC0, 1'b1}, {3'h4, 8'h10, 8'h10, 1'b0}};
    localparam swc_rst_src_t RSTS [4] = '{5'b11000, 5'b00110, 5'b00001, 5'b10000};
    logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic sleepExec, wdogTick, cpuClkEnable, deviceReset, lowFreqOscEnable, secTimerOscEnable;
    logic capSenseOscEnable, adcClockEnable, portHold, wdogTimeout, found;
    logic [PADDR_W-1:0] sleepAddr;
    logic [IRQ_W-1:0] irqFlags;
    swc_rst_src_t rstSrcPin;
    swc_wake_t wakeInfo;
    int miscompares, checkCount;
    swc_ctrl u_swc_ctrl (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sleepExec, .sleepAddr, .wdogTick, .irqFlags, .rstSrcPin, .cpuClkEnable,
        .deviceReset, .wakeInfo, .lowFreqOscEnable, .secTimerOscEnable, .capSenseOscEnable,
        .adcClockEnable, .portHold, .wdogTimeout);
    swc_core_model u_swc_core_model (.core_clk, .cpuClkEnable, .sleepExec, .sleepAddr, .wdogTick,
        .irqFlags, .rstSrcPin);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic close_out();
        if (miscompares == 0 && checkCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo();
        miscompares++;
        close_out();
    endtask : tmo
    // Ready lines of the master stay high, so no response is ever held off
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        if (n == 100) tmo();
    endtask : axiWrite
    task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n == 100) tmo();
    endtask : axiRead
    task automatic waitWake(input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge core_clk);
            if (wakeInfo.resumed === 1'b1) break;
        end
        if (n == lim) tmo();
    endtask : waitWake
    task automatic enterSleep(input logic [PADDR_W-1:0] a, input logic adcRc);
        chk(32'(cpuClkEnable), 32'h1);
        u_swc_core_model.execSleep(a);
        // The ADC enable follows one cycle after the sleep state is reached
        repeat (3) @(posedge core_clk);
        chk(32'(cpuClkEnable), 32'h0);
        chk(32'(portHold), 32'h1);
        chk(32'({lowFreqOscEnable, secTimerOscEnable, capSenseOscEnable}), 32'h7);
        chk(32'(adcClockEnable), 32'(adcRc));
        axiRead(STATUS_OFFSET, rd, resp);
        chk(rd, 32'h6);
        axiRead(WDOG_OFFSET, rd, resp);
        chk(rd, 32'h0);
    endtask : enterSleep
    initial begin
        miscompares = 0;
        checkCount = 0;
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        foreach (ROWS[i]) begin
            axiWrite(CTRL_OFFSET, 32'(ROWS[i].ctrl), resp);
            axiWrite(IRQEN_OFFSET, 32'(ROWS[i].irqEn), resp);
            enterSleep(15'(i), ROWS[i].ctrl[2]);
            u_swc_core_model.setIrq(ROWS[i].irq);
            waitWake(50);
            chk(32'(wakeInfo.callIsr), 32'(ROWS[i].callIsr));
            chk(32'(wakeInfo.fetchAddr), 32'(i + 1));
            chk(32'(cpuClkEnable), 32'h1);
            u_swc_core_model.setIrq(8'h00);
            axiRead(WDOG_OFFSET, rd, resp);
            chk(rd, 32'h0);
            axiRead(STATUS_OFFSET, rd, resp);
            chk(rd, 32'h2);
        end
        // Masked request must not wake; enabling it while asleep must
        axiWrite(CTRL_OFFSET, 32'h1, resp);
        axiWrite(IRQEN_OFFSET, 32'h02, resp);
        enterSleep(15'h7FFF, 1'b0);
        u_swc_core_model.setIrq(8'h01);
        repeat (20) @(posedge core_clk);
        chk(32'(cpuClkEnable), 32'h0);
        axiRead(WAKE_OFFSET, rd, resp);
        chk(rd, 32'h1);
        axiWrite(IRQEN_OFFSET, 32'h01, resp);
        waitWake(50);
        chk(32'({wakeInfo.callIsr, wakeInfo.fetchAddr}), 32'h8000);
        u_swc_core_model.setIrq(8'h00);
        axiWrite(IRQEN_OFFSET, 32'h0, resp);
        foreach (RSTS[i]) begin
            enterSleep(15'h0040, 1'b0);
            u_swc_core_model.setRst(RSTS[i]);
            found = 1'b0;
            repeat (20) @(posedge core_clk) if (deviceReset === 1'b1) found = 1'b1;
            chk(32'(found), 32'(i < 3));
            u_swc_core_model.setRst('0);
            repeat (10) @(posedge core_clk);
            chk(32'(deviceReset), 32'h0);
            axiRead(STATUS_OFFSET, rd, resp);
            chk(rd, (i < 3) ? 32'h3 : 32'h6);
        end
        // Still asleep after the disabled pin: the watchdog must wake it
        axiWrite(CTRL_OFFSET, 32'h2, resp);
        u_swc_core_model.setTick(1'b1);
        waitWake(70000);
        u_swc_core_model.setTick(1'b0);
        chk(32'(wakeInfo.callIsr), 32'h0);
        axiRead(STATUS_OFFSET, rd, resp);
        chk(rd, 32'h0);
        // Cleared at wake, then two more ticks pass before the tick is stopped
        axiRead(WDOG_OFFSET, rd, resp);
        chk(rd, 32'h2);
        axiRead(PADDR_OFFSET, rd, resp);
        chk(rd, 32'h41);
        axiRead(12'h018, rd, resp);
        chk(rd, 32'h0);
        chk(32'(resp), 32'(RESP_SLVERR));
        axiWrite(WDOG_OFFSET, 32'h1234, resp);
        chk(32'(resp), 32'(RESP_OKAY));
        // A write with its low byte lane off must leave the control bits alone
        s_axi_wstrb <= 4'h0;
        axiWrite(CTRL_OFFSET, 32'h7, resp);
        s_axi_wstrb <= 4'hF;
        axiRead(CTRL_OFFSET, rd, resp);
        chk(rd, 32'h2);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(32'({cpuClkEnable, adcClockEnable, portHold, deviceReset, wdogTimeout}), 32'h18);
        axiRead(CTRL_OFFSET, rd, resp);
        chk(rd, 32'(CTRL_RESET));
        axiRead(IRQEN_OFFSET, rd, resp);
        chk(rd, 32'(IRQEN_RESET));
        close_out();
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        tmo();
    end
endmodule : swc_ctrl_test
